// >>> hw/dbg_pkg.sv
/*
 * Constants for the single-wire debug command decoder: command codes,
 * field lengths, status bit positions, reset values and the idle limit.
 * Assumes a bit-level line driver outside that turns pin pulses into bits.
 */
`default_nettype none
package dbg_pkg;
	// Command codes sent by the host pod
	localparam logic [7:0] cmd_mcu_reset        = 8'h18;
	localparam logic [7:0] cmd_background       = 8'h90;
	localparam logic [7:0] cmd_rd_status        = 8'hE4;
	localparam logic [7:0] cmd_wr_control       = 8'hC4;
	localparam logic [7:0] cmd_mem_rd           = 8'hE0;
	localparam logic [7:0] cmd_mem_rd_with_stat = 8'hE1;
	localparam logic [7:0] cmd_mem_wr           = 8'hC0;
	localparam logic [7:0] cmd_mem_wr_with_stat = 8'hC1;
	localparam logic [7:0] cmd_get_breakpoint   = 8'hE2;
	localparam logic [7:0] cmd_set_breakpoint   = 8'hC2;
	localparam logic [7:0] cmd_go               = 8'h08;
	localparam logic [7:0] cmd_single_step      = 8'h10;
	localparam logic [7:0] cmd_block_rd         = 8'h80;
	localparam logic [7:0] cmd_block_wr         = 8'h88;
	localparam logic [7:0] cmd_get_acc          = 8'h68;
	localparam logic [7:0] cmd_set_acc          = 8'h48;
	localparam logic [7:0] cmd_get_flags_pc     = 8'h6B;
	localparam logic [7:0] cmd_set_flags_pc     = 8'h4B;
	localparam logic [7:0] cmd_get_shadow_pc    = 8'h6F;
	localparam logic [7:0] cmd_set_shadow_pc    = 8'h4F;
	// Field lengths in bits
	localparam logic [4:0] LEN_BYTE = 5'h08;
	localparam logic [4:0] LEN_WORD = 5'h10;
	localparam int         ADDR_W   = 14;
	// Quiet cycles after the last host falling edge that mean soft-reset
	localparam logic [9:0] IDLE_RESET_CYC = 10'h200;
	// Status byte bit positions and reset value of the stored low bits
	localparam int         STAT_EN_BIT  = 7;
	localparam int         STAT_ACT_BIT = 6;
	localparam logic [5:0] CTRL_RST     = 6'h00;
	// Target of a CPU register write
	localparam logic [1:0] SEL_ACC      = 2'h0;
	localparam logic [1:0] SEL_FLAGS_PC = 2'h1;
	localparam logic [1:0] SEL_SHADOW   = 2'h2;
	// Decoder states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CMD  = 3'b001,
		S_ADDR = 3'b010,
		S_WDAT = 3'b011,
		S_MEM  = 3'b100,
		S_TX   = 3'b101
	} dbg_state_t;
endpackage : dbg_pkg
`default_nettype wire

// >>> hw/debug_controller.sv
/*
 * Command decoder of the single-wire debug controller, target side.
 * Assumes a same-clock line driver for bits, sync pulses and edges,
 * a memory port with req/ack, and a CPU that halts while active is set.
 */
//
// Function
// R01: commands open with eight-bit code, MSB first
// R02: every field travels MSB first
// R03: host waits 16 to 511 cycles per delay
// R04: 512 quiet cycles end any command
// R05: address keeps only its low 14 bits
// R06: data fields are 8 or 16 bits
// R07: sync request answered with reference pulse
// R08: code 18 requests full MCU reset
// R09: code 90 halts CPU only when enabled
// R10: never halt while enable clear; code keeps active when C4 clears enable and sets it after a step
// R11: E4 reads, C4 writes status/control
// R12: E0 reads byte, E1 adds status first
// R13: C0 writes byte, C1 then returns status
// R14: E2 reads, C2 writes breakpoint register
// R15: halted-only commands ignored while CPU runs
// R16: code 08 resumes user program
// R17: code 10 runs one instruction, halts again
// R18: code 80 streams bytes from rising addresses
// R19: code 88 writes bytes to rising addresses
// R20: 68 reads, 48 writes accumulator
// R21: 6B/4B move flags over program counter
// R22: 6F/4F move shadow program counter
`default_nettype none
module debug_controller (
	input  wire logic                  core_clk,                 // 10 MHz clock
	input  wire logic                  rst,                      // Async reset
	input  wire logic                  host_fall,                // Pulse: host edge
	input  wire logic                  rx_valid,                 // Pulse: host bit
	input  wire logic                  rx_bit,                   // Host bit value
	input  wire logic                  tx_ready,                 // Pulse: send bit
	output logic                       tx_bit,                   // Target bit
	output logic                       tx_active,                // Target field on
	input  wire logic                  sync_req,                 // Pulse: sync seen
	output logic                       sync_ack,                 // Pulse: send ref
	output logic                       mem_req,                  // Memory request
	output logic                       mem_we,                   // Write request
	output logic [dbg_pkg::ADDR_W-1:0] mem_addr,                 // Byte address
	output logic [7:0]                 mem_wdata,                // Write byte
	input  wire logic [7:0]            mem_rdata,                // Read byte
	input  wire logic                  mem_ack,                  // Pulse: done
	input  wire logic [7:0]            cpu_acc,                  // Accumulator
	input  wire logic [1:0]            cpu_zc,                   // Zero, carry
	input  wire logic [13:0]           cpu_pc,                   // Program counter
	input  wire logic [13:0]           cpu_shadow_pc,            // Shadow counter
	output logic                       cpu_wr,                   // Pulse: reg write
	output logic [1:0]                 cpu_wr_sel,               // Which register
	output logic [15:0]                cpu_wdata,                // Value to load
	output logic                       cpu_step,                 // Pulse: one step
	input  wire logic                  cpu_step_done,            // Pulse: step over
	output logic                       bgnd_active,              // CPU halted
	output logic                       mcu_reset_req,            // Pulse: reset
	output logic [7:0]                 debug_status_control_reg, // Status byte
	output logic [15:0]                breakpoint_match_reg      // Breakpoint
);
	import dbg_pkg::*;

	typedef struct packed {
		dbg_state_t  st;       // Decoder state
		logic [7:0]  cmd;      // Command in progress
		logic [13:0] addr;     // Current address
		logic [7:0]  wdata;    // Byte for memory
		logic        en;       // Debug enable bit
		logic        active;   // Background mode active
		logic        stepping; // One instruction running
		logic [5:0]  ctrl;     // Stored low status bits
		logic [15:0] bkpt;     // Breakpoint match value
		logic [9:0]  idle;     // Quiet cycle count
		logic        mem_req;  // Memory request level
		logic        mem_we;   // Request is a write
		logic        cpu_wr;   // CPU register write pulse
		logic [1:0]  wr_sel;   // CPU register chosen
		logic [15:0] cpu_wd;   // CPU register value
		logic        step;     // Step pulse
		logic        mcu_rst;  // Reset request pulse
		logic        sync_ack; // Reference pulse request
		logic        sh_start; // Field start pulse
		logic        sh_tx;    // Field direction
		logic [4:0]  sh_len;   // Field length
		logic [15:0] sh_word;  // Field value to send
	} ctl_t;

	ctl_t       q;
	ctl_t       d;
	logic [7:0] rx_cmd;  // Command byte just received
	logic       soft_rst; // Quiet limit reached this cycle

	shift_if sif ();

	// Starts a field and names the state that waits for it
	function automatic ctl_t shift_go(ctl_t s, logic tx, logic [4:0] len,
			logic [15:0] w, dbg_state_t nx);
		s.sh_start = 1'b1;
		s.sh_tx    = tx;
		s.sh_len   = len;
		s.sh_word  = w;
		s.st       = nx;
		return s;
	endfunction : shift_go

	// Raises a memory request at the current address
	function automatic ctl_t mem_go(ctl_t s, logic we);
		s.mem_req = 1'b1;
		s.mem_we  = we;
		s.st      = S_MEM;
		return s;
	endfunction : mem_go

	// Commands that only run while the CPU is halted
	function automatic logic halted_only(logic [7:0] c);
		return c == cmd_go || c == cmd_single_step || c == cmd_block_rd
			|| c == cmd_block_wr || c == cmd_get_acc || c == cmd_set_acc
			|| c == cmd_get_flags_pc || c == cmd_set_flags_pc
			|| c == cmd_get_shadow_pc || c == cmd_set_shadow_pc;
	endfunction : halted_only

	// Status byte as the host sees it
	function automatic logic [7:0] status(ctl_t s);
		return {s.en, s.active, s.ctrl};
	endfunction : status

	assign rx_cmd   = sif.rx_word[7:0];
	assign soft_rst = !host_fall && q.idle == IDLE_RESET_CYC - 10'h001;

	// Next state of the whole decoder
	always_comb begin
		d          = q;
		d.sh_start = 1'b0;
		d.cpu_wr   = 1'b0;
		d.step     = 1'b0;
		d.mcu_rst  = 1'b0;
		// Reference pulse request works in any state  // see R07
		d.sync_ack = sync_req;
		// Quiet counter, restarted by each host falling edge
		if (host_fall) begin
			d.idle = 10'h000;
		end else if (q.idle != IDLE_RESET_CYC) begin
			d.idle = q.idle + 10'h001;
		end
		// Step finished: back to background  // see R17
		if (q.stepping && cpu_step_done) begin
			d.stepping = 1'b0;
			d.active   = 1'b1;
		end
		unique case (q.st)
			S_IDLE: begin // Wait for a command byte  // see R01
				d = shift_go(d, 1'b0, LEN_BYTE, 16'h0000, S_CMD);
			end
			S_CMD: if (sif.done) begin
				d.cmd = rx_cmd;
				d.st  = S_IDLE;
				// Running CPU: halted-only codes are dropped  // see R15
				if (!(halted_only(rx_cmd) && !q.active)) begin
					case (rx_cmd)
						cmd_mcu_reset: d.mcu_rst = 1'b1; // see R08
						cmd_background: begin // Gated by enable  // see R09
							if (q.en) begin
								d.active = 1'b1; // see R10
							end
						end
						cmd_rd_status: d = shift_go(d, 1'b1, LEN_BYTE,
							{8'h00, status(q)}, S_TX); // see R11
						cmd_get_breakpoint: d = shift_go(d, 1'b1, LEN_WORD,
							q.bkpt, S_TX); // see R14
						cmd_go: d.active = 1'b0; // see R16
						cmd_single_step: begin // see R17
							d.active   = 1'b0;
							d.stepping = 1'b1;
							d.step     = 1'b1;
						end
						cmd_get_acc: d = shift_go(d, 1'b1, LEN_BYTE,
							{8'h00, cpu_acc}, S_TX); // see R20
						cmd_get_flags_pc: d = shift_go(d, 1'b1, LEN_WORD,
							{cpu_zc, cpu_pc}, S_TX); // see R21
						cmd_get_shadow_pc: d = shift_go(d, 1'b1, LEN_WORD,
							{2'b00, cpu_shadow_pc}, S_TX); // see R22
						cmd_mem_rd, cmd_mem_rd_with_stat, cmd_mem_wr,
						cmd_mem_wr_with_stat, cmd_block_rd, cmd_block_wr:
							d = shift_go(d, 1'b0, LEN_WORD, 16'h0000, S_ADDR);
						cmd_wr_control, cmd_set_acc:
							d = shift_go(d, 1'b0, LEN_BYTE, 16'h0000, S_WDAT);
						cmd_set_breakpoint, cmd_set_flags_pc, cmd_set_shadow_pc:
							d = shift_go(d, 1'b0, LEN_WORD, 16'h0000, S_WDAT);
						default: ; // Unknown codes are ignored
					endcase
				end
			end
			S_ADDR: if (sif.done) begin
				// Bits 15 and 14 are dropped  // see R05
				d.addr = sif.rx_word[ADDR_W-1:0];
				if (q.cmd == cmd_mem_rd || q.cmd == cmd_mem_rd_with_stat
						|| q.cmd == cmd_block_rd) begin
					// Read during the host's delay slot  // see R03
					d = mem_go(d, 1'b0);
				end else begin
					d = shift_go(d, 1'b0, LEN_BYTE, 16'h0000, S_WDAT);
				end
			end
			S_WDAT: if (sif.done) begin
				d.st     = S_IDLE;
				d.cpu_wd = sif.rx_word;
				case (q.cmd)
					cmd_wr_control: begin // Active bit is read-only  // see R11
						d.en   = sif.rx_word[STAT_EN_BIT];
						d.ctrl = sif.rx_word[5:0];
					end
					cmd_set_breakpoint: d.bkpt = sif.rx_word; // see R14
					cmd_set_acc: begin // see R20
						d.cpu_wr = 1'b1;
						d.wr_sel = SEL_ACC;
					end
					cmd_set_flags_pc: begin // see R21
						d.cpu_wr = 1'b1;
						d.wr_sel = SEL_FLAGS_PC;
					end
					cmd_set_shadow_pc: begin // Top bits cleared  // see R22
						d.cpu_wr = 1'b1;
						d.wr_sel = SEL_SHADOW;
						d.cpu_wd = {2'b00, sif.rx_word[13:0]};
					end
					default: begin // Memory write commands  // see R13
						d.wdata = sif.rx_word[7:0];
						d       = mem_go(d, 1'b1);
					end
				endcase
			end
			S_MEM: if (mem_ack) begin
				d.mem_req = 1'b0;
				d.st      = S_IDLE;
				if (q.mem_we) begin
					if (q.cmd == cmd_mem_wr_with_stat) begin // see R13
						d = shift_go(d, 1'b1, LEN_BYTE, {8'h00, status(q)}, S_TX);
					end else if (q.cmd == cmd_block_wr) begin // see R19
						d.addr = q.addr + 14'h0001;
						d      = shift_go(d, 1'b0, LEN_BYTE, 16'h0000, S_WDAT);
					end
				end else if (q.cmd == cmd_mem_rd_with_stat) begin
					// Status goes out ahead of the data  // see R12
					d = shift_go(d, 1'b1, LEN_WORD, {status(q), mem_rdata}, S_TX);
				end else begin // see R12
					d = shift_go(d, 1'b1, LEN_BYTE, {8'h00, mem_rdata}, S_TX);
				end
			end
			S_TX: if (sif.done) begin
				if (q.cmd == cmd_block_rd) begin // Next byte up  // see R18
					d.addr = q.addr + 14'h0001;
					d      = mem_go(d, 1'b0);
				end else begin
					d.st = S_IDLE;
				end
			end
			default: d.st = S_IDLE;
		endcase
		// Long quiet line ends any command, blocks included  // see R04
		if (soft_rst) begin
			d.st      = S_IDLE;
			d.mem_req = 1'b0;
		end
	end

	// State register; reset leaves enable clear and the CPU running
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sif.start   = q.sh_start;
	assign sif.tx_mode = q.sh_tx;
	assign sif.len     = q.sh_len;
	assign sif.tx_word = q.sh_word;

	// Field shifter on the link side
	debug_shifter u_shifter (
		.core_clk  (core_clk),
		.rst       (rst),
		.rx_valid  (rx_valid),
		.rx_bit    (rx_bit),
		.tx_ready  (tx_ready),
		.tx_bit    (tx_bit),
		.tx_active (tx_active),
		.sif       (sif.shifter)
	);

	assign sync_ack                 = q.sync_ack;
	assign mem_req                  = q.mem_req;
	assign mem_we                   = q.mem_we;
	assign mem_addr                 = q.addr;
	assign mem_wdata                = q.wdata;
	assign cpu_wr                   = q.cpu_wr;
	assign cpu_wr_sel               = q.wr_sel;
	assign cpu_wdata                = q.cpu_wd;
	assign cpu_step                 = q.step;
	assign bgnd_active              = q.active;
	assign mcu_reset_req            = q.mcu_rst;
	assign debug_status_control_reg = status(q);
	assign breakpoint_match_reg     = q.bkpt;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_soft;
		soft_rst |=> q.st == S_IDLE && !mem_req ##1 sif.start && sif.len == LEN_BYTE;
	endproperty
	a_soft: assert property (p_soft) else $error("soft-reset not taken"); // see R04

	property p_addr;
		(q.st == S_ADDR && sif.done) |=> mem_addr == $past(sif.rx_word[13:0]);
	endproperty
	a_addr: assert property (p_addr) else $error("address not truncated"); // see R05

	property p_sync;
		sync_req |=> sync_ack;
	endproperty
	a_sync: assert property (p_sync) else $error("sync not answered"); // see R07

	property p_rst;
		(q.st == S_CMD && sif.done && rx_cmd == cmd_mcu_reset) |=> mcu_reset_req ##1 !mcu_reset_req;
	endproperty
	a_rst: assert property (p_rst) else $error("reset request wrong"); // see R08

	property p_bg;
		(q.st == S_CMD && sif.done && rx_cmd == cmd_background && !q.stepping)
			|=> bgnd_active == ($past(q.en) || $past(q.active));
	endproperty
	a_bg: assert property (p_bg) else $error("background gate wrong"); // see R09

	property p_noact;
		(!q.en && !q.active && !q.stepping) |=> !bgnd_active;
	endproperty
	a_noact: assert property (p_noact) else $error("halted while disabled"); // see R10

	property p_ctrl;
		(q.st == S_WDAT && sif.done && q.cmd == cmd_wr_control)
			|=> debug_status_control_reg[STAT_EN_BIT] == $past(sif.rx_word[7]);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control write lost"); // see R11

	property p_e1;
		(q.st == S_MEM && mem_ack && !mem_we && q.cmd == cmd_mem_rd_with_stat && !soft_rst)
			|=> sif.start && sif.len == LEN_WORD && sif.tx_word[7:0] == $past(mem_rdata);
	endproperty
	a_e1: assert property (p_e1) else $error("status read word wrong"); // see R12

	property p_bkpt;
		(q.st == S_WDAT && sif.done && q.cmd == cmd_set_breakpoint)
			|=> breakpoint_match_reg == $past(sif.rx_word);
	endproperty
	a_bkpt: assert property (p_bkpt) else $error("breakpoint not loaded"); // see R14

	property p_intr;
		(q.st == S_CMD && sif.done && halted_only(rx_cmd) && !q.active)
			|=> q.st == S_IDLE && !cpu_step && !mem_req ##1 !cpu_wr;
	endproperty
	a_intr: assert property (p_intr) else $error("halted-only command ran"); // see R15

	property p_go;
		(q.st == S_CMD && sif.done && rx_cmd == cmd_go && q.active) |=> !bgnd_active;
	endproperty
	a_go: assert property (p_go) else $error("go did not resume"); // see R16

	property p_step;
		(q.stepping && cpu_step_done) |=> bgnd_active && !q.stepping;
	endproperty
	a_step: assert property (p_step) else $error("step did not return"); // see R17
endmodule : debug_controller
`default_nettype wire

// >>> hw/debug_shifter.sv
/*
 * Field shifter: moves one 8- or 16-bit field over the debug link.
 * Assumes a same-clock line driver giving one-cycle bit strobes.
 */
`default_nettype none
module debug_shifter (
	input  wire logic  core_clk,  // System clock
	input  wire logic  rst,       // Async reset, high
	input  wire logic  rx_valid,  // Pulse: host bit received
	input  wire logic  rx_bit,    // Received bit value
	input  wire logic  tx_ready,  // Pulse: line takes next target bit
	output logic       tx_bit,    // Next target bit to send
	output logic       tx_active, // Target field in progress
	shift_if.shifter   sif        // Decoder side
);
	import dbg_pkg::*;

	typedef struct packed {
		logic        rx_busy; // Collecting host bits
		logic        tx_busy; // Sending target bits
		logic [4:0]  cnt;     // Bits still to go
		logic [15:0] sh;      // Shift register, MSB at the line
		logic        done;    // Completion pulse
	} shf_t;

	shf_t q;
	shf_t d;

	// Next state; a new start reloads everything, so no abort is needed
	always_comb begin
		d      = q;
		d.done = 1'b0;
		if (sif.start) begin
			d.rx_busy = !sif.tx_mode;
			d.tx_busy = sif.tx_mode;
			d.cnt     = sif.len;
			// Left align so the MSB goes first  // see R02
			d.sh      = sif.tx_word << (LEN_WORD - sif.len);
		end else if ((q.rx_busy && rx_valid) || (q.tx_busy && tx_ready)) begin
			// Shift in at the bottom, out at the top  // see R01
			d.sh  = {q.sh[14:0], q.rx_busy ? rx_bit : 1'b0};
			d.cnt = q.cnt - 5'h01;
			if (q.cnt == 5'h01) begin // Last bit of 8 or 16  // see R06
				d.rx_busy = 1'b0;
				d.tx_busy = 1'b0;
				d.done    = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tx_bit      = q.sh[15];
	assign tx_active   = q.tx_busy;
	assign sif.done    = q.done;
	assign sif.rx_word = q.sh;
endmodule : debug_shifter
`default_nettype wire

// >>> hw/shift_if.sv
/*
 * Carrier between the command decoder and its field shifter.
 * Assumes both ends run on the same clock.
 */
`default_nettype none
interface shift_if;
	logic        start;   // Pulse: begin a field
	logic        tx_mode; // Field goes target to host
	logic [4:0]  len;     // Field length in bits
	logic [15:0] tx_word; // Value to send, right aligned
	logic        done;    // Pulse: field complete
	logic [15:0] rx_word; // Received value, right aligned
	modport ctrl (output start, tx_mode, len, tx_word, input done, rx_word);
	modport shifter (input start, tx_mode, len, tx_word, output done, rx_word);
endinterface : shift_if
`default_nettype wire

// >>> sim/debug_controller_tb_top.sv
/*
 * Self-checking bench for the debug command decoder.
 * Assumes a memory that acks in four cycles and a CPU that steps at once.
 */
`default_nettype none
module debug_controller_tb_top import dbg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, rst = 1'b1, sync_req = 1'b0, mem_ack = 1'b0, cpu_step_done = 1'b0;
	logic host_fall, rx_valid, rx_bit, tx_ready, tx_bit, tx_active, sync_ack, mem_req, mem_we;
	logic cpu_wr, cpu_step, bgnd_active, mcu_reset_req;
	logic [13:0] mem_addr, cpu_pc = 14'h0000, cpu_shadow_pc = 14'h0000;
	logic [7:0]  mem_wdata, debug_status_control_reg, mem_rdata = 8'h00, cpu_acc = 8'h00;
	logic [1:0]  cpu_zc = 2'h0, cpu_wr_sel, w_sel;
	logic [15:0] cpu_wdata, breakpoint_match_reg, w_dat, v, a, bk;
	logic [5:0]  lo;                   // Stored control bits
	logic [31:0] r, seed = 32'h53EECA07;
	logic [7:0]  mem [0:16383];        // Target memory
	logic [7:0]  gc [3] = '{cmd_get_acc, cmd_get_flags_pc, cmd_get_shadow_pc};
	logic [7:0]  sc [3] = '{cmd_set_acc, cmd_set_flags_pc, cmd_set_shadow_pc};
	int          gl [3] = '{8, 16, 16};
	int          n_mismatch = 0, compares = 0, n_step = 0, n_rst = 0, lat = 0;
	always #50 core_clk = ~core_clk;
	debug_controller i_dut (.core_clk, .rst, .host_fall, .rx_valid, .rx_bit, .tx_ready, .tx_bit,
		.tx_active, .sync_req, .sync_ack, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
		.mem_ack, .cpu_acc, .cpu_zc, .cpu_pc, .cpu_shadow_pc, .cpu_wr, .cpu_wr_sel, .cpu_wdata,
		.cpu_step, .cpu_step_done, .bgnd_active, .mcu_reset_req, .debug_status_control_reg,
		.breakpoint_match_reg);
	host_pod i_pod (.core_clk, .tx_bit, .tx_active, .host_fall, .rx_valid, .rx_bit, .tx_ready);
	initial begin
		foreach (mem[i]) mem[i] = 8'(i * 7);
	end
	// Memory, CPU and event monitor; ack is late on purpose
	always @(posedge core_clk) begin
		mem_ack       <= 1'b0;
		cpu_step_done <= cpu_step;
		if (cpu_wr) begin
			w_sel <= cpu_wr_sel;
			w_dat <= cpu_wdata;
		end
		if (cpu_step) n_step <= n_step + 1;
		if (mcu_reset_req) n_rst <= n_rst + 1;
		if (!mem_req || mem_ack) lat <= 0;
		else if (lat == 3) begin
			mem_ack   <= 1'b1;
			mem_rdata <= mem[mem_addr];
			if (mem_we) mem[mem_addr] <= mem_wdata;
		end else lat <= lat + 1;
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function logic [7:0] stat(input logic en, input logic act);
		return {en, act, lo};
	endfunction : stat
	function logic [15:0] cpu_val(input int k);
		case (k)
			0: return {8'h00, cpu_acc};
			1: return {cpu_zc, cpu_pc};
			default: return {2'b00, cpu_shadow_pc};
		endcase
	endfunction : cpu_val
	function logic [15:0] wr_val(input int k, input logic [15:0] x);
		case (k)
			0: return {8'h00, x[7:0]};
			1: return x;
			default: return {2'b00, x[13:0]};
		endcase
	endfunction : wr_val
	task chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task cmd(input logic [7:0] c);
		i_pod.send({8'h00, c}, 8);
	endtask : cmd
	task dl();
		i_pod.gap(16 + int'(rnd() % 16));
	endtask : dl
	task end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// Watchdog
	initial begin
		repeat (40000) @(posedge core_clk);
		n_mismatch++;
		end_sim();
	end
	// Main sequence
	initial begin
		lo = 6'h00;
		repeat (10) @(posedge core_clk);
		r = rnd();
		{cpu_acc, cpu_zc, cpu_pc} <= r[23:0];
		cpu_shadow_pc <= r[31:18];
		rst <= 1'b0;
		@(posedge core_clk);
		sync_req <= 1'b1;
		@(posedge core_clk);
		sync_req <= 1'b0;
		@(negedge core_clk);
		chk(16'(sync_ack), 16'h1);
		cmd(cmd_background);
		dl();
		chk(16'(bgnd_active), 16'h0);
		cmd(cmd_rd_status);
		i_pod.recv(8, v);
		chk(v, {8'h00, stat(1'b0, 1'b0)});
		// Halted-only code is dropped while running, soft-reset recovers
		cmd(cmd_get_acc);
		i_pod.gap(40);
		chk(16'(tx_active), 16'h0);
		i_pod.quiet();
		r = rnd();
		lo = r[5:0];
		cmd(cmd_wr_control);
		i_pod.send({8'h00, 1'b1, r[6:0]}, 8);
		cmd(cmd_rd_status);
		i_pod.recv(8, v);
		chk(v, {8'h00, stat(1'b1, 1'b0)});
		cmd(cmd_background);
		dl();
		chk({8'h00, debug_status_control_reg}, {8'h00, stat(1'b1, 1'b1)});
		bk = 16'(rnd());
		cmd(cmd_set_breakpoint);
		i_pod.send(bk, 16);
		cmd(cmd_get_breakpoint);
		i_pod.recv(16, v);
		chk(v, bk);
		chk(breakpoint_match_reg, bk);
		// Random addresses with bits 15:14 set or not
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			cmd(k[0] ? cmd_mem_wr_with_stat : cmd_mem_wr);
			i_pod.send(r[31:16], 16);
			i_pod.send(r[15:0], 8);
			dl();
			if (k[0]) i_pod.recv(8, v);
			if (k[0]) chk(v, {8'h00, stat(1'b1, 1'b1)});
			chk({8'h00, mem[r[29:16]]}, {8'h00, r[7:0]});
			cmd(k[0] ? cmd_mem_rd_with_stat : cmd_mem_rd);
			i_pod.send(r[31:16] ^ 16'h0001, 16);
			dl();
			i_pod.recv(k[0] ? 16 : 8, v);
			chk(v, {k[0] ? stat(1'b1, 1'b1) : 8'h00, mem[r[29:16] ^ 14'h0001]});
		end
		for (int k = 0; k < 3; k++) begin
			r = rnd();
			cmd(gc[k]);
			dl();
			i_pod.recv(gl[k], v);
			chk(v, cpu_val(k));
			cmd(sc[k]);
			i_pod.send(r[15:0], gl[k]);
			dl();
			chk({14'h0000, w_sel}, 16'(k));
			chk(w_dat, wr_val(k, r[15:0]));
		end
		a = 16'(rnd());
		cmd(cmd_block_rd);
		i_pod.send(a, 16);
		for (int j = 0; j < 3; j++) begin
			dl();
			i_pod.recv(8, v);
			chk(v, {8'h00, mem[a[13:0] + 14'(j)]});
		end
		i_pod.quiet();
		cmd(cmd_block_wr);
		i_pod.send(a, 16);
		for (int j = 0; j < 3; j++) begin
			r = rnd();
			i_pod.send(r[15:0], 8);
			dl();
			chk({8'h00, mem[a[13:0] + 14'(j)]}, {8'h00, r[7:0]});
		end
		i_pod.quiet();
		cmd(cmd_single_step);
		dl();
		chk(16'(n_step), 16'h1);
		chk(16'(bgnd_active), 16'h1);
		cmd(cmd_go);
		dl();
		chk(16'(bgnd_active), 16'h0);
		cmd(cmd_get_breakpoint);
		i_pod.recv(16, v);
		chk(v, bk);
		cmd(cmd_mcu_reset);
		i_pod.gap(8);
		chk(16'(n_rst), 16'h1);
		end_sim();
	end
endmodule : debug_controller_tb_top
`default_nettype wire

// >>> sim/host_pod.sv
/*
 * Host debug pod model: sends host fields and clocks target fields out.
 * Assumes the line driver is reduced to one-cycle bit strobes on core_clk.
 */
`default_nettype none
module host_pod (
	input  wire logic core_clk,  // Clock
	input  wire logic tx_bit,    // Target bit
	input  wire logic tx_active, // Target field on
	output var logic  host_fall, // Host edge
	output var logic  rx_valid,  // Host bit strobe
	output var logic  rx_bit,    // Host bit value
	output var logic  tx_ready   // Take target bit
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		host_fall = 1'b0;
		rx_valid  = 1'b0;
		rx_bit    = 1'b1;
		tx_ready  = 1'b0;
	end
	// One bit per four cycles leaves the decoder time to re-arm
	task send(input logic [15:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge core_clk);
			rx_valid  <= 1'b1;
			rx_bit    <= v[i];
			host_fall <= 1'b1;
			@(posedge core_clk);
			rx_valid  <= 1'b0;
			host_fall <= 1'b0;
			// Released line must not keep looking valid
			rx_bit    <= ~v[i];
			repeat (2) @(posedge core_clk);
		end
	endtask : send
	// Delay slot, callers pass 8 to 40 cycles
	task gap(input int c);
		repeat (c) @(posedge core_clk);
	endtask : gap
	// Soft-reset: no host edge for more than 512 cycles
	task quiet();
		repeat (520) @(posedge core_clk);
	endtask : quiet
	// Target field, bit taken at the edge that consumes it
	task recv(input int n, output logic [15:0] v);
		int w;
		v = 16'h0000;
		w = 0;
		while (tx_active !== 1'b1 && w < 40) begin
			@(posedge core_clk);
			w++;
		end
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			tx_ready  <= 1'b1;
			host_fall <= 1'b1;
			@(posedge core_clk);
			v = {v[14:0], tx_bit};
			tx_ready  <= 1'b0;
			host_fall <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
	endtask : recv
endmodule : host_pod
`default_nettype wire
